// [rtl/homing_pkg.sv]
// Package: register map, field codes and state types for the homing sequencer
package homing_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;

  // APB word offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_HIGH_SPEED = 8'h08;
  localparam logic [7:0] REG_LOW_SPEED = 8'h0C;
  localparam logic [7:0] REG_RAMP = 8'h10;
  localparam logic [7:0] REG_OFFSET = 8'h14;
  localparam logic [7:0] REG_GEAR = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_ABS_POS = 8'h20;
  localparam logic [7:0] REG_MOVE = 8'h24;

  // CTRL fields
  localparam int CTRL_TRIG_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  // CFG fields
  localparam int CFG_METHOD_LSB = 0;
  localparam int CFG_MODE_LSB = 4;
  localparam int CFG_LIMSEL_LSB = 8;
  localparam int CFG_STOPMODE_LSB = 12;

  localparam logic [3:0] CFG_METHOD_RST = 4'h0;
  localparam logic [3:0] CFG_MODE_RST = 4'h0;
  localparam logic [1:0] CFG_LIMSEL_RST = 2'h0;
  localparam logic [31:0] GEAR_RST = 32'h0000_0001;

  // Enable-method codes
  localparam logic [3:0] METH_OFF0 = 4'h0;
  localparam logic [3:0] METH_HOME_START = 4'h1;
  localparam logic [3:0] METH_ELEC_START = 4'h2;
  localparam logic [3:0] METH_HOME_SON_A = 4'h3;
  localparam logic [3:0] METH_HOME_SON_B = 4'h4;
  localparam logic [3:0] METH_ELEC_SON = 4'h5;

  // Reference kinds selected by mode code divided by two
  localparam logic [2:0] REF_SWITCH = 3'h0;
  localparam logic [2:0] REF_INDEX = 3'h1;
  localparam logic [2:0] REF_SW_INDEX = 3'h2;
  localparam logic [2:0] REF_LIMIT = 3'h3;
  localparam logic [2:0] REF_LIM_INDEX = 3'h4;
  localparam logic [2:0] REF_STOP = 3'h5;
  localparam logic [2:0] REF_STOP_INDEX = 3'h6;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_FAST_FWD,
    ST_FAST_REV,
    ST_RAMP_REV,
    ST_SLOW_REV,
    ST_SLOW_FWD,
    ST_INDEX_SEEK,
    ST_LIMIT_WAIT,
    ST_OFFSET_MOVE,
    ST_DONE
  } search_state_t;

  typedef struct packed {
    logic home_sw;
    logic index;
    logic fwd_lim;
    logic rev_lim;
    logic end_stop;
  } sensors_t;

  typedef struct packed {
    logic signed [31:0] speed;
    logic run;
    logic stop_req;
    logic [1:0] stop_mode;
  } motion_cmd_t;
endpackage

// [rtl/servo_homing_sequencer.sv]
// Homing sequencer: APB registers, input edge detection and search FSM
//
// Overview of operation
// RQ1: Homing requests are ignored while fly change or multi-position runs.
// RQ2: Zero target equals located home plus configured offset.
// RQ3: Search starts only with servo-on, position mode and trigger.
// RQ4: Other references and repeat triggers are rejected while homing runs.
// RQ5: Home attaining finds the mechanical reference, then moves the offset.
// RQ6: Electric homing moves (offset minus position) times gear, signed.
// RQ7: On completion absolute position is loaded with home offset.
// RQ8: Completion raises home-found or offset-move output, mode independent.
// RQ9: Host waits for completion output before new position references.
// RQ10: Method 0,6 off; 1 start,3,4 servo-on; 2 start,5 servo-on electric.
// RQ11: Reference filters are bypassed while homing is active.
// RQ12: Limit during homing warns; setting 0 or 1 also stops (stops only for the limit ahead in the fast forward phase).
// RQ13: Even modes 0..12 pick forward searches with the listed references.
// RQ14: Odd modes mirror their even counterpart with directions reversed.
// RQ15: Switch inactive: high speed forward until decel rising edge.
// RQ16: On rising edge ramp to negative low speed, seek falling edge.
// RQ17: After falling edge go forward slow, seek home rising edge.
// RQ18: Stop at once on home rising edge in final forward phase.
// RQ19: Switch active at start: skip fast phase, reverse slow first.
// RQ20: Limit in fast phase: setting 2,3 reverse; 0,1 stop and wait.
// RQ21: After a resolved limit, search reverse at high speed.
// RQ22: Inputs are synchronised and edges found from consecutive samples.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module servo_homing_sequencer
  import homing_pkg::*;
#(
  parameter int unsigned RAMP_CYC_PER_MS = CLK_HZ / 1000
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SERVO_ON_I,
  input wire logic POS_MODE_I,
  input wire logic HOME_SEARCH_TRIGGER_I,
  input wire logic FLY_CHANGE_BUSY_I,
  input wire logic MULTI_POS_BUSY_I,
  input wire homing_pkg::sensors_t SENSORS_I,
  input wire logic MOVE_DONE_I,
  output homing_pkg::motion_cmd_t MOTION_O,
  output logic REF_ACCEPT_O,
  output logic FILTER_BYPASS_O,
  output logic HOME_FOUND_DONE_O,
  output logic OFFSET_MOVE_DONE_O,
  output logic FWD_LIMIT_WARNING_O,
  output logic REV_LIMIT_WARNING_O
);
  import homing_pkg::*;

  initial begin
    if (RAMP_CYC_PER_MS < 1) begin
      $error("RAMP_CYC_PER_MS must be at least 1");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [3:0] homing_enable_method;
  logic [3:0] homing_search_mode;
  logic [1:0] limit_handling_select;
  logic [1:0] overtravel_stop_mode;
  logic signed [31:0] high_search_speed;
  logic signed [31:0] low_search_speed;
  logic [15:0] search_ramp_time;
  logic signed [31:0] home_offset;
  logic signed [31:0] gear_ratio;
  logic signed [31:0] absolute_position_count;
  logic signed [31:0] offset_move;
  logic sw_trigger;
  logic sw_clear;
  search_state_t state;
  logic home_found_done;
  logic offset_move_done;
  logic fwd_limit_warning;
  logic rev_limit_warning;

  logic wr_en;
  logic rd_en;
  logic addr_ok;
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_en = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;
  // Map is contiguous aligned words from CTRL up to MOVE
  assign addr_ok = PADDR_I[1:0] == 2'h0 && PADDR_I <= REG_MOVE;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      homing_enable_method <= CFG_METHOD_RST;
      homing_search_mode <= CFG_MODE_RST;
      limit_handling_select <= CFG_LIMSEL_RST;
      overtravel_stop_mode <= 2'h0;
      high_search_speed <= 32'sh0000_0000;
      low_search_speed <= 32'sh0000_0000;
      search_ramp_time <= 16'h0000;
      home_offset <= 32'sh0000_0000;
      gear_ratio <= GEAR_RST;
    end else if (wr_en) begin
      case (PADDR_I)
        REG_CFG: begin
          homing_enable_method <= PWDATA_I[CFG_METHOD_LSB +: 4];
          homing_search_mode <= PWDATA_I[CFG_MODE_LSB +: 4];
          limit_handling_select <= PWDATA_I[CFG_LIMSEL_LSB +: 2];
          overtravel_stop_mode <= PWDATA_I[CFG_STOPMODE_LSB +: 2];
        end
        REG_HIGH_SPEED: high_search_speed <= PWDATA_I;
        REG_LOW_SPEED: low_search_speed <= PWDATA_I;
        REG_RAMP: search_ramp_time <= PWDATA_I[15:0];
        REG_OFFSET: home_offset <= PWDATA_I;
        REG_GEAR: gear_ratio <= PWDATA_I;
        default: ;
      endcase
    end
  end

  // Control strobes: one-cycle pulses from CTRL writes
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sw_trigger <= 1'b0;
      sw_clear <= 1'b0;
    end else begin
      sw_trigger <= wr_en && PADDR_I == REG_CTRL && PWDATA_I[CTRL_TRIG_BIT];
      sw_clear <= wr_en && PADDR_I == REG_CTRL && PWDATA_I[CTRL_CLR_BIT];
    end
  end

  // Read data latched in setup, valid in access
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (rd_en) begin
      case (PADDR_I)
        REG_CFG: PRDATA_O <= {18'h0_0000, overtravel_stop_mode, 2'h0,
                              limit_handling_select, homing_search_mode,
                              homing_enable_method};
        REG_HIGH_SPEED: PRDATA_O <= high_search_speed;
        REG_LOW_SPEED: PRDATA_O <= low_search_speed;
        REG_RAMP: PRDATA_O <= {16'h0000, search_ramp_time};
        REG_OFFSET: PRDATA_O <= home_offset;
        REG_GEAR: PRDATA_O <= gear_ratio;
        REG_STATUS: PRDATA_O <= {24'h00_0000, state, rev_limit_warning,
                                 fwd_limit_warning, offset_move_done,
                                 home_found_done};
        REG_ABS_POS: PRDATA_O <= absolute_position_count;
        REG_MOVE: PRDATA_O <= offset_move;
        default: PRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection
  localparam int NIN = 8;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1;
  logic [NIN-1:0] sync2;
  logic [NIN-1:0] prev;
  logic [NIN-1:0] rise;
  logic [NIN-1:0] fall;
  assign raw_in = {SERVO_ON_I, HOME_SEARCH_TRIGGER_I, SENSORS_I.end_stop,
                   SENSORS_I.rev_lim, SENSORS_I.fwd_lim, SENSORS_I.index,
                   SENSORS_I.home_sw, POS_MODE_I};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          prev[gi] <= 1'b0;
        end else begin
          sync1[gi] <= raw_in[gi];
          sync2[gi] <= sync1[gi];
          prev[gi] <= sync2[gi]; // [RQ22]
        end
      end
      assign rise[gi] = sync2[gi] && !prev[gi]; // [RQ22]
      assign fall[gi] = !sync2[gi] && prev[gi]; // [RQ22]
    end
  endgenerate

  logic pos_mode;
  logic servo_on;
  assign pos_mode = sync2[0];
  assign servo_on = sync2[7];

  ////////////////////////////////////////////////////////////////////////
  // Mode decode: direction flip for odd codes, reference from code/2
  logic rev_dir;
  logic [2:0] ref_kind;
  logic use_index;
  logic [2:0] ref_kind_raw;
  assign rev_dir = homing_search_mode[0]; // [RQ14]
  assign ref_kind_raw = homing_search_mode[3:1]; // [RQ13]
  assign ref_kind = ref_kind_raw > REF_STOP_INDEX ? REF_SWITCH : ref_kind_raw;
  assign use_index = ref_kind == REF_SW_INDEX || ref_kind == REF_LIM_INDEX ||
                     ref_kind == REF_STOP_INDEX;

  // Decel reference level and edges; only the limit reference is mirrored for reverse modes
  logic [2:0] dec_idx;
  logic [2:0] lim_idx;
  logic dec_lvl;
  logic dec_rise;
  logic dec_fall;
  logic ahead_lim_rise;
  assign lim_idx = rev_dir ? 3'h4 : 3'h3;
  always_comb begin
    case (ref_kind)
      REF_INDEX: dec_idx = 3'h2;
      REF_LIMIT, REF_LIM_INDEX: dec_idx = lim_idx;
      REF_STOP, REF_STOP_INDEX: dec_idx = 3'h5;
      default: dec_idx = 3'h1;
    endcase
  end
  assign dec_lvl = sync2[dec_idx];
  assign dec_rise = rise[dec_idx];
  assign dec_fall = fall[dec_idx];
  assign ahead_lim_rise = rise[lim_idx];

  // Method decode
  logic meth_home;
  logic meth_elec;
  logic meth_son;
  assign meth_home = homing_enable_method == METH_HOME_START ||
                     homing_enable_method == METH_HOME_SON_A ||
                     homing_enable_method == METH_HOME_SON_B; // [RQ10]
  assign meth_elec = homing_enable_method == METH_ELEC_START ||
                     homing_enable_method == METH_ELEC_SON; // [RQ10]
  assign meth_son = homing_enable_method == METH_HOME_SON_A ||
                    homing_enable_method == METH_HOME_SON_B ||
                    homing_enable_method == METH_ELEC_SON; // [RQ10]

  logic trig;
  logic busy_other;
  logic start_ok;
  assign busy_other = FLY_CHANGE_BUSY_I || MULTI_POS_BUSY_I;
  assign trig = meth_son ? rise[7] : (rise[6] || sw_trigger); // [RQ10]
  assign start_ok = trig && servo_on && pos_mode && !busy_other &&
                    (meth_home || meth_elec); // [RQ1] [RQ3]

  ////////////////////////////////////////////////////////////////////////
  // Ramp timer: search_ramp_time milliseconds converted to cycles
  logic [31:0] ramp_cnt;
  logic ramp_busy;
  logic ramp_load;
  assign ramp_busy = ramp_cnt != 32'h0000_0000;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ramp_cnt <= 32'h0000_0000;
    end else if (ramp_load) begin
      ramp_cnt <= 32'(search_ramp_time * RAMP_CYC_PER_MS);
    end else if (ramp_busy) begin
      ramp_cnt <= ramp_cnt - 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Search state machine
  logic signed [31:0] hi;
  logic signed [31:0] lo;
  logic lim_stop;
  logic homing_active;
  logic signed [63:0] move_prod;
  assign hi = rev_dir ? -high_search_speed : high_search_speed;
  assign lo = rev_dir ? -low_search_speed : low_search_speed;
  assign lim_stop = limit_handling_select < 2'd2;
  assign homing_active = state != ST_IDLE && state != ST_DONE;
  assign move_prod = (home_offset - absolute_position_count) * gear_ratio;
  assign ramp_load = state == ST_FAST_FWD && dec_rise;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= ST_IDLE;
      MOTION_O <= '0;
      offset_move <= 32'sh0000_0000;
    end else begin
      case (state)
        ST_IDLE, ST_DONE: begin
          MOTION_O.run <= 1'b0;
          MOTION_O.stop_req <= 1'b0;
          if (start_ok && meth_elec) begin
            offset_move <= move_prod[31:0]; // [RQ6]
            MOTION_O.speed <= move_prod[63] ? -low_search_speed
                                            : low_search_speed; // [RQ6]
            MOTION_O.run <= 1'b1;
            state <= ST_OFFSET_MOVE;
          end else if (start_ok) begin
            MOTION_O.run <= 1'b1;
            if (dec_lvl) begin
              MOTION_O.speed <= -lo; // [RQ19]
              state <= ST_SLOW_REV;
            end else begin
              MOTION_O.speed <= hi; // [RQ15]
              state <= ST_FAST_FWD;
            end
          end
        end
        ST_FAST_FWD: begin
          if (ahead_lim_rise && lim_stop) begin
            MOTION_O.run <= 1'b0;
            MOTION_O.stop_req <= 1'b1; // [RQ20]
            MOTION_O.stop_mode <= overtravel_stop_mode; // [RQ12]
            state <= ST_LIMIT_WAIT;
          end else if (ahead_lim_rise) begin
            MOTION_O.speed <= -hi; // [RQ20] [RQ21]
            state <= ST_FAST_REV;
          end else if (dec_rise) begin
            MOTION_O.speed <= -lo; // [RQ16]
            state <= ST_RAMP_REV;
          end
        end
        ST_RAMP_REV: begin
          if (!ramp_busy) begin
            state <= ST_SLOW_REV; // [RQ16]
          end
        end
        ST_LIMIT_WAIT: begin
          MOTION_O.stop_req <= 1'b0;
          if (trig && !busy_other) begin
            MOTION_O.run <= 1'b1;
            MOTION_O.speed <= -hi; // [RQ21]
            state <= ST_FAST_REV;
          end
        end
        ST_FAST_REV, ST_SLOW_REV: begin
          if (dec_fall) begin
            MOTION_O.speed <= lo; // [RQ17]
            state <= ST_SLOW_FWD;
          end
        end
        ST_SLOW_FWD: begin
          if (dec_rise && use_index) begin
            state <= ST_INDEX_SEEK; // [RQ5]
          end else if (dec_rise) begin
            MOTION_O.speed <= home_offset; // [RQ2] [RQ18]
            state <= ST_OFFSET_MOVE;
          end
        end
        ST_INDEX_SEEK: begin
          if (rise[2]) begin
            MOTION_O.speed <= home_offset; // [RQ2] [RQ5]
            state <= ST_OFFSET_MOVE;
          end
        end
        ST_OFFSET_MOVE: begin
          if (MOVE_DONE_I) begin
            MOTION_O.run <= 1'b0;
            state <= ST_DONE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Absolute position, completion flags, limit warnings
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      absolute_position_count <= 32'sh0000_0000;
    end else if (state == ST_OFFSET_MOVE && MOVE_DONE_I) begin
      absolute_position_count <= home_offset; // [RQ7]
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      home_found_done <= 1'b0;
      offset_move_done <= 1'b0;
    end else if (state == ST_OFFSET_MOVE && MOVE_DONE_I) begin
      home_found_done <= !meth_elec; // [RQ8]
      offset_move_done <= meth_elec; // [RQ8]
    end else if (start_ok && !homing_active) begin
      home_found_done <= 1'b0;
      offset_move_done <= 1'b0;
    end
  end

  // Set wins over clear
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fwd_limit_warning <= 1'b0;
      rev_limit_warning <= 1'b0;
    end else begin
      if (homing_active && rise[3]) begin
        fwd_limit_warning <= 1'b1; // [RQ12]
      end else if (sw_clear) begin
        fwd_limit_warning <= 1'b0;
      end
      if (homing_active && rise[4]) begin
        rev_limit_warning <= 1'b1; // [RQ12]
      end else if (sw_clear) begin
        rev_limit_warning <= 1'b0;
      end
    end
  end

  assign REF_ACCEPT_O = !homing_active; // [RQ4] [RQ9]
  assign FILTER_BYPASS_O = homing_active; // [RQ11]
  assign HOME_FOUND_DONE_O = home_found_done;
  assign OFFSET_MOVE_DONE_O = offset_move_done;
  assign FWD_LIMIT_WARNING_O = fwd_limit_warning;
  assign REV_LIMIT_WARNING_O = rev_limit_warning;
endmodule

// [test/host_model.sv]
// Host model: homing trigger pulses and motion-finished answers
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_req_i,
  input wire logic finish_req_i,
  input wire logic done_i,
  output logic trigger_o,
  output logic move_done_o,
  output logic waiting_o
);
  logic [2:0] trig_cnt;
  logic [1:0] fin_cnt;
  // Trigger held four cycles so the synchroniser cannot miss it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_cnt <= 3'h0;
    end else if (start_req_i) begin
      trig_cnt <= 3'h4;
    end else if (trig_cnt != 3'h0) begin
      trig_cnt <= trig_cnt - 3'h1;
    end
  end
  assign trigger_o = (trig_cnt != 3'h0);
  // Motion end answered slowly, three cycles late, as a single pulse
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fin_cnt <= 2'h0;
    end else if (finish_req_i) begin
      fin_cnt <= 2'h3;
    end else if (fin_cnt != 2'h0) begin
      fin_cnt <= fin_cnt - 2'h1;
    end
  end
  assign move_done_o = (fin_cnt == 2'h1);
  // No new reference until completion is seen
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      waiting_o <= 1'b0;
    end else if (start_req_i) begin
      waiting_o <= 1'b1;
    end else if (done_i) begin
      waiting_o <= 1'b0;
    end
  end
endmodule

// [test/servo_homing_sequencer_checker.sv]
// Checker: port-level properties of the homing sequencer
`timescale 1ns/1ps
module servo_homing_sequencer_checker (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic FLY_CHANGE_BUSY_I,
  input wire logic MULTI_POS_BUSY_I,
  input wire logic MOVE_DONE_I,
  input wire homing_pkg::motion_cmd_t MOTION_O,
  input wire logic REF_ACCEPT_O,
  input wire logic FILTER_BYPASS_O,
  input wire logic HOME_FOUND_DONE_O,
  input wire logic OFFSET_MOVE_DONE_O
);
  import homing_pkg::*;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  ////////////////////////////////////////////////////////////////////////////
  property p_refuse;
    FILTER_BYPASS_O |-> !REF_ACCEPT_O;
  endproperty
  a_refuse: assert property (p_refuse) else $error("ref accepted");
  property p_busy;
    (FLY_CHANGE_BUSY_I || MULTI_POS_BUSY_I) && !FILTER_BYPASS_O
      |=> !FILTER_BYPASS_O;
  endproperty
  a_busy: assert property (p_busy) else $error("start while busy");
  property p_excl;
    !(HOME_FOUND_DONE_O && OFFSET_MOVE_DONE_O);
  endproperty
  a_excl: assert property (p_excl) else $error("both done");
  property p_home_stop;
    $rose(HOME_FOUND_DONE_O) |-> !MOTION_O.run;
  endproperty
  a_home_stop: assert property (p_home_stop) else $error("run at done");
  property p_home_cause;
    $rose(HOME_FOUND_DONE_O) |-> $past(MOVE_DONE_I);
  endproperty
  a_home_cause: assert property (p_home_cause) else $error("early done");
  property p_start_run;
    $rose(FILTER_BYPASS_O) |-> ##[0:1] MOTION_O.run;
  endproperty
  a_start_run: assert property (p_start_run) else $error("no run");
  property p_done_hold;
    $fell(HOME_FOUND_DONE_O) |-> ##[0:1] FILTER_BYPASS_O;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("flag lost");
  property p_elec_stop;
    $rose(OFFSET_MOVE_DONE_O) |-> !MOTION_O.run && !HOME_FOUND_DONE_O;
  endproperty
  a_elec_stop: assert property (p_elec_stop) else $error("elec end");
  c_home: cover property ($rose(HOME_FOUND_DONE_O));
  c_elec: cover property ($rose(OFFSET_MOVE_DONE_O));
  c_start: cover property ($rose(FILTER_BYPASS_O));
endmodule

bind servo_homing_sequencer servo_homing_sequencer_checker
  i_servo_homing_sequencer_checker (
  .MCLK_I(MCLK_I),
  .RST_N_I(RST_N_I),
  .FLY_CHANGE_BUSY_I(FLY_CHANGE_BUSY_I),
  .MULTI_POS_BUSY_I(MULTI_POS_BUSY_I),
  .MOVE_DONE_I(MOVE_DONE_I),
  .MOTION_O(MOTION_O),
  .REF_ACCEPT_O(REF_ACCEPT_O),
  .FILTER_BYPASS_O(FILTER_BYPASS_O),
  .HOME_FOUND_DONE_O(HOME_FOUND_DONE_O),
  .OFFSET_MOVE_DONE_O(OFFSET_MOVE_DONE_O)
);

// [test/servo_homing_sequencer_tb.sv]
// Testbench: directed homing scenarios over APB and the host model
`timescale 1ns/1ps
module servo_homing_sequencer_tb;
  import homing_pkg::*;
  logic clk, rst_n, psel, pen, pwr, servo, posm, fly, multi, err;
  logic start_req, fin_req, trig, mvdone, waiting, pready, pslverr;
  logic ref_acc, fbyp, hdone, edone, fwarn, rwarn;
  logic [3:0] flg;
  assign flg = {rwarn, fwarn, edone, hdone};
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  sensors_t sens;
  motion_cmd_t motion;
  int errors, compares, cyc;
  localparam logic [31:0] HI = 32'h0000_03E8;
  localparam logic [31:0] LO = 32'h0000_0064;
  localparam logic [31:0] OFS = 32'h0000_0040;
  servo_homing_sequencer #(.RAMP_CYC_PER_MS(2)) i_servo_homing_sequencer (
    .MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SERVO_ON_I(servo),
    .POS_MODE_I(posm), .HOME_SEARCH_TRIGGER_I(trig),
    .FLY_CHANGE_BUSY_I(fly), .MULTI_POS_BUSY_I(multi), .SENSORS_I(sens),
    .MOVE_DONE_I(mvdone), .MOTION_O(motion), .REF_ACCEPT_O(ref_acc),
    .FILTER_BYPASS_O(fbyp), .HOME_FOUND_DONE_O(hdone),
    .OFFSET_MOVE_DONE_O(edone), .FWD_LIMIT_WARNING_O(fwarn),
    .REV_LIMIT_WARNING_O(rwarn));
  host_model i_host_model (.clk_i(clk), .rst_n_i(rst_n),
    .start_req_i(start_req), .finish_req_i(fin_req),
    .done_i(hdone | edone), .trigger_o(trig), .move_done_o(mvdone),
    .waiting_o(waiting));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // Whole run needs well under ten thousand cycles
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    rd = prdata;
  endtask
  task automatic wait_spd(input logic [31:0] v);
    int n = 0;
    while (motion.speed !== v && n < 80) begin
      @(posedge clk);
      n++;
    end
    chk("speed", motion.speed, v);
  endtask
  task automatic wait_flag(input int s);
    int n = 0;
    while (flg[s] !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("flag", 32'(flg[s]), 32'h1);
  endtask
  task automatic req(input bit fin);
    @(posedge clk);
    start_req <= !fin;
    fin_req <= fin;
    @(posedge clk);
    start_req <= 1'b0;
    fin_req <= 1'b0;
  endtask
  task automatic son_toggle();
    @(posedge clk);
    servo <= 1'b0;
    repeat (4) @(posedge clk);
    servo <= 1'b1;
  endtask
  task automatic setup(input int m, input int md, input int ls);
    @(posedge clk);
    rst_n <= 1'b0;
    sens <= '0;
    {servo, posm} <= 2'h3;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b1, REG_HIGH_SPEED, HI);
    apb(1'b1, REG_LOW_SPEED, LO);
    apb(1'b1, REG_RAMP, 32'h1);
    apb(1'b1, REG_OFFSET, OFS);
    // Stop mode 2 placed in bits 13:12
    apb(1'b1, REG_CFG, 32'(m) | 32'(md) << 4 | 32'(ls) << 8 | 32'h2000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    setup(0, 0, 0);
    apb(1'b0, REG_GEAR, '0);
    chk("gear reset", rd, GEAR_RST);
    apb(1'b0, 8'h40, '0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("regs test done");
  endtask
  task automatic t_home();
    setup(1, 0, 0);
    req(0);
    wait_spd(HI);
    chk("ref accept", 32'(ref_acc), 32'h0);
    chk("bypass", 32'(fbyp), 32'h1);
    req(0);
    repeat (8) @(posedge clk);
    chk("retrigger", motion.speed, HI);
    sens.home_sw <= 1'b1;
    wait_spd(-LO);
    sens.home_sw <= 1'b0;
    wait_spd(LO);
    sens.home_sw <= 1'b1;
    wait_spd(OFS);
    req(1);
    wait_flag(0);
    chk("run", 32'(motion.run), 32'h0);
    chk("elec flag", 32'(edone), 32'h0);
    apb(1'b0, REG_ABS_POS, '0);
    chk("abs pos", rd, OFS);
    chk("ref again", 32'(ref_acc), 32'h1);
    {servo, posm} <= 2'h0;
    repeat (6) @(posedge clk);
    chk("flag kept", 32'(hdone), 32'h1);
    $display("home test done");
  endtask
  task automatic t_modes();
    for (int md = 0; md < 13; md++) begin
      setup(1, md, 0);
      req(0);
      wait_spd((md % 2) ? -HI : HI);
    end
    setup(1, 0, 0);
    sens.home_sw <= 1'b1;
    repeat (4) @(posedge clk);
    req(0);
    wait_spd(-LO);
    sens.home_sw <= 1'b0;
    wait_spd(LO);
    $display("modes test done");
  endtask
  task automatic t_limit();
    for (int ls = 0; ls < 4; ls += 2) begin
      setup(1, ls / 2, ls);
      req(0);
      wait_spd(ls ? -HI : HI);
      sens <= ls ? 5'h02 : 5'h04;
      wait_flag(ls ? 3 : 2);
      if (ls == 0) begin
        chk("stop", 32'({motion.stop_req, motion.stop_mode}),
            32'h6);
        sens <= '0;
        req(0);
      end
      wait_spd(ls ? HI : -HI);
      sens <= '0;
      repeat (4) @(posedge clk);
      apb(1'b1, REG_CTRL, 32'h2);
      repeat (2) @(posedge clk);
      chk("warn clear", 32'({rwarn, fwarn}), 32'h0);
    end
    $display("limit test done");
  endtask
  task automatic t_elec();
    setup(2, 0, 0);
    req(0);
    wait_spd(LO);
    apb(1'b0, REG_MOVE, '0);
    chk("move", rd, OFS);
    req(1);
    wait_flag(1);
    chk("home flag", 32'(hdone), 32'h0);
    apb(1'b0, REG_ABS_POS, '0);
    chk("abs elec", rd, OFS);
    chk("host wait", 32'(waiting), 32'h0);
    apb(1'b1, REG_OFFSET, 32'h10);
    apb(1'b1, REG_GEAR, 32'h2);
    apb(1'b1, REG_CFG, 32'(METH_ELEC_SON));
    son_toggle();
    wait_spd(-LO);
    apb(1'b0, REG_MOVE, '0);
    chk("move neg", rd, 32'hFFFF_FFA0);
    req(1);
    wait_flag(1);
    apb(1'b0, REG_ABS_POS, '0);
    chk("abs elec 2", rd, 32'h10);
    $display("electric test done");
  endtask
  task automatic t_refuse();
    for (int m = 0; m < 7; m++) begin
      if (m == 2 || m == 5) continue;
      setup(m, 0, 0);
      if (m > 2) son_toggle();
      else req(0);
      repeat (8) @(posedge clk);
      chk("method", 32'(fbyp), (m == 0 || m == 6) ? 32'h0 : 32'h1);
    end
    for (int k = 0; k < 3; k++) begin
      setup(1, 0, 0);
      {fly, multi, posm} <= (k == 0) ? 3'h5 : (k == 1) ? 3'h3 : 3'h0;
      req(0);
      repeat (8) @(posedge clk);
      chk("blocked", 32'(fbyp), 32'h0);
      {fly, multi} <= 2'h0;
    end
    $display("refuse test done");
  endtask
  initial begin
    {rst_n, psel, pen, pwr, fly, multi, start_req, fin_req} = 8'h0;
    {servo, posm} = 2'h3;
    {paddr, pwdata, rd, err} = '0;
    sens = '0;
    {errors, compares, cyc} = '0;
    t_regs();
    t_home();
    t_modes();
    t_limit();
    t_elec();
    t_refuse();
    tally_and_finish();
  end
endmodule
